/* File: verilog/sseq_pkg.sv */
// Purpose: Shared constants and types for the signalling sequence checker.
// Assumes: One clock at 20 MHz; one PSTN path per checker instance.
// Notes:   Both ends of the link use the same numbers and message layout.

`default_nettype none

package sseq_pkg;

    // ========================================================================
    // Sequence numbering
    // ========================================================================
    localparam int SEQ_W = 7;
    localparam logic [6:0] SEQ_RESET = 7'h00;
    localparam logic [6:0] SEQ_ONE = 7'h01;
    // Largest number of unacknowledged messages in flight.
    localparam logic [6:0] SEQ_WINDOW = 7'h7F;

    typedef logic [SEQ_W-1:0] sseq_seq_t;

    // ========================================================================
    // Timing
    // ========================================================================
    localparam int unsigned CLK_HZ = 20000000;
    localparam int unsigned ACK_WAIT_MS = 10000;
    localparam int unsigned ACK_SEND_MS = 5000;
    localparam int unsigned ACK_WAIT_CYC = ACK_WAIT_MS * (CLK_HZ / 1000);
    localparam int unsigned ACK_SEND_CYC = ACK_SEND_MS * (CLK_HZ / 1000);
    // Timer counters are wide enough for the 10 s figure at 20 MHz.
    localparam int TMR_W = 28;

    typedef logic [TMR_W-1:0] sseq_tmr_t;

endpackage : sseq_pkg

`default_nettype wire

/* File: verilog/sseq_link_if.sv */
// Purpose: Message link between the two peer sequence checkers.
// Assumes: Both peers share ref_clk_i; each message is a one-cycle pulse.
// Notes:   The receiving peer always takes a message; there is no ready.

`timescale 1ns/1ns
`default_nettype none

interface sseq_link_if;
    import sseq_pkg::*;

    // ========================================================================
    // Access network to exchange direction
    // ========================================================================
    logic a2l_valid;
    logic a2l_ack;
    logic a2l_param;
    sseq_seq_t a2l_seq;

    // ========================================================================
    // Exchange to access network direction
    // ========================================================================
    logic l2a_valid;
    logic l2a_ack;
    logic l2a_param;
    sseq_seq_t l2a_seq;

    modport an_mp (
        output a2l_valid, a2l_ack, a2l_param, a2l_seq,
        input l2a_valid, l2a_ack, l2a_param, l2a_seq
    );

    modport le_mp (
        output l2a_valid, l2a_ack, l2a_param, l2a_seq,
        input a2l_valid, a2l_ack, a2l_param, a2l_seq
    );

endinterface : sseq_link_if

`default_nettype wire

/* File: verilog/sseq_an_end.sv */
// Purpose: Sequence checker engine and the access network end of the link.
// Assumes: Link inputs come from the peer on the same clock.
// Notes:   The checker is symmetric; the exchange end reuses the engine.
//
// Operation
// - Sequence numbers count modulo 128.
// - Three counters cleared when idle call starts.
// - Stamp send number, then advance it.
// - Window overrun beyond 127 releases path.
// - Start ack wait timer only if idle.
// - Acknowledgement reports current expected number.
// - In-order message accepted, otherwise path released.
// - Acknowledgement stops, restarts timer, or releases.
// - Acknowledged value must lie inside window.
// - Start ack send timer unless running.
// - Ack send timer expiry sends acknowledgement.
// - Ack wait timer expiry releases path.
// - Ack wait timer lasts 10 seconds.
// - Ack send timer lasts 5 seconds.
// - Link re-establishment indication may be ignored.
// - Signals and parameters protected; release one path.

`timescale 1ns/1ns
`default_nettype none

module sseq_engine #(
    parameter int unsigned ACK_WAIT_CYC = sseq_pkg::ACK_WAIT_CYC,
    parameter int unsigned ACK_SEND_CYC = sseq_pkg::ACK_SEND_CYC
) (
    // Clock and reset.
    input wire logic ref_clk_i,
    input wire logic reset_i,
    // Call control from the PSTN protocol state machine.
    input wire logic call_start_i,
    input wire logic send_req_i,
    input wire logic send_param_i,
    // Messages arriving from the peer.
    input wire logic rx_valid_i,
    input wire logic rx_ack_i,
    input wire logic rx_param_i,
    input wire sseq_pkg::sseq_seq_t rx_seq_i,
    // Messages leaving toward the peer.
    output logic tx_valid_o,
    output logic tx_ack_o,
    output logic tx_param_o,
    output sseq_pkg::sseq_seq_t tx_seq_o,
    // Status toward the PSTN protocol state machine.
    output logic rx_accept_o,
    output logic rx_accept_param_o,
    output logic release_o,
    output logic active_o
);
    import sseq_pkg::*;

    // Timer reload values, one less because expiry is seen at zero.
    localparam sseq_tmr_t WAIT_LOAD = TMR_W'(ACK_WAIT_CYC - 1);
    localparam sseq_tmr_t SEND_LOAD = TMR_W'(ACK_SEND_CYC - 1);

    // ========================================================================
    // State
    // ========================================================================
    logic active_r;
    sseq_seq_t send_seq_r;
    sseq_seq_t acked_seq_r;
    sseq_seq_t expect_seq_r;
    logic wait_run_r;
    sseq_tmr_t wait_cnt_r;
    logic send_run_r;
    sseq_tmr_t send_cnt_r;
    logic ack_pend_r;

    // ========================================================================
    // Event decode
    // ========================================================================
    logic start_call;
    logic send_ovf;
    logic do_send;
    logic rx_sig;
    logic rx_bad;
    logic rx_good;
    logic rx_ackm;
    logic ack_in_win;
    logic ack_bad;
    logic ack_ok;
    logic ack_all;
    logic wait_exp;
    logic send_exp;
    logic rel;
    logic ack_go;
    sseq_seq_t outstanding;
    sseq_seq_t ack_ahead;

    // A new call is only taken while the path is idle.
    assign start_call = call_start_i && !active_r;

    // Sent but not yet acknowledged, modulo 128 by natural wrap.
    assign outstanding = send_seq_r - acked_seq_r;
    assign send_ovf = active_r && send_req_i && (outstanding == SEQ_WINDOW);
    assign do_send = active_r && send_req_i && !send_ovf;

    // Line signals and protocol parameters take the same check.
    assign rx_sig = active_r && rx_valid_i && !rx_ack_i;
    assign rx_good = rx_sig && (rx_seq_i == expect_seq_r);
    assign rx_bad = rx_sig && (rx_seq_i != expect_seq_r);

    // An acknowledgement may neither go backwards nor pass the sender.
    assign rx_ackm = active_r && rx_valid_i && rx_ack_i;
    assign ack_ahead = rx_seq_i - acked_seq_r;
    assign ack_in_win = (ack_ahead <= outstanding);
    assign ack_bad = rx_ackm && !ack_in_win;
    assign ack_ok = rx_ackm && ack_in_win;
    assign ack_all = ack_ok && (rx_seq_i == send_seq_r);

    assign wait_exp = wait_run_r && (wait_cnt_r == '0);
    assign send_exp = send_run_r && (send_cnt_r == '0);

    // Any fault clears this path only; other instances are untouched.
    assign rel = send_ovf || rx_bad || ack_bad || wait_exp;

    // A queued acknowledgement yields the slot to an outgoing signal.
    assign ack_go = active_r && ack_pend_r && !do_send;

    // ========================================================================
    // Path activity and release request
    // ========================================================================
    // The path stays busy from call start until a fault or reset.
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            active_r <= 1'b0;
            release_o <= 1'b0;
        end else begin
            release_o <= rel;
            if (start_call) begin
                active_r <= 1'b1;
            end else if (rel) begin
                active_r <= 1'b0;
            end
        end
    end

    assign active_o = active_r;

    // ========================================================================
    // Sequence counters
    // ========================================================================
    // Re-establishment of the data link needs no input here: a lost
    // message shows up as a gap or a wait timeout anyway.
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            send_seq_r <= SEQ_RESET;
            acked_seq_r <= SEQ_RESET;
            expect_seq_r <= SEQ_RESET;
        end else if (start_call) begin
            send_seq_r <= SEQ_RESET;
            acked_seq_r <= SEQ_RESET;
            expect_seq_r <= SEQ_RESET;
        end else if (!rel) begin
            if (do_send) begin
                send_seq_r <= send_seq_r + SEQ_ONE;
            end
            if (ack_ok) begin
                acked_seq_r <= rx_seq_i;
            end
            if (rx_good) begin
                expect_seq_r <= expect_seq_r + SEQ_ONE;
            end
        end
    end

    // ========================================================================
    // Acknowledgement wait timer
    // ========================================================================
    // A send while the timer runs leaves it alone, so the wait is measured
    // from the send that found it idle, or from the latest partial acknowledgement.
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            wait_run_r <= 1'b0;
            wait_cnt_r <= '0;
        end else if (rel || !active_r) begin
            wait_run_r <= 1'b0;
            wait_cnt_r <= '0;
        end else if ((ack_ok && !ack_all) ||
                     (do_send && (!wait_run_r || ack_all))) begin
            wait_run_r <= 1'b1;
            wait_cnt_r <= WAIT_LOAD;
        end else if (ack_all) begin
            wait_run_r <= 1'b0;
            wait_cnt_r <= '0;
        end else if (wait_run_r) begin
            wait_cnt_r <= wait_cnt_r - 1'b1;
        end
    end

    // ========================================================================
    // Acknowledgement send timer
    // ========================================================================
    // Not restarted by later messages, so one acknowledgement can cover
    // several of them.
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            send_run_r <= 1'b0;
            send_cnt_r <= '0;
        end else if (rel || !active_r || send_exp) begin
            send_run_r <= 1'b0;
            send_cnt_r <= '0;
        end else if (rx_good && !send_run_r) begin
            send_run_r <= 1'b1;
            send_cnt_r <= SEND_LOAD;
        end else if (send_run_r) begin
            send_cnt_r <= send_cnt_r - 1'b1;
        end
    end

    // Expiry queues one acknowledgement until the link slot is free.
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            ack_pend_r <= 1'b0;
        end else if (rel || !active_r) begin
            ack_pend_r <= 1'b0;
        end else if (send_exp) begin
            ack_pend_r <= 1'b1;
        end else if (ack_go) begin
            ack_pend_r <= 1'b0;
        end
    end

    // ========================================================================
    // Outgoing messages
    // ========================================================================
    // A line signal wins the slot; a pending acknowledgement goes next.
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            tx_valid_o <= 1'b0;
            tx_ack_o <= 1'b0;
            tx_param_o <= 1'b0;
            tx_seq_o <= SEQ_RESET;
        end else if (do_send && !rel) begin
            tx_valid_o <= 1'b1;
            tx_ack_o <= 1'b0;
            tx_param_o <= send_param_i;
            tx_seq_o <= send_seq_r;
        end else if (ack_go && !rel) begin
            tx_valid_o <= 1'b1;
            tx_ack_o <= 1'b1;
            tx_param_o <= 1'b0;
            tx_seq_o <= expect_seq_r;
        end else begin
            tx_valid_o <= 1'b0;
            tx_ack_o <= 1'b0;
            tx_param_o <= 1'b0;
        end
    end

    // ========================================================================
    // Accepted message indication
    // ========================================================================
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            rx_accept_o <= 1'b0;
            rx_accept_param_o <= 1'b0;
        end else begin
            rx_accept_o <= rx_good && !rel;
            rx_accept_param_o <= rx_good && !rel && rx_param_i;
        end
    end

endmodule : sseq_engine

// ============================================================================
// Access network end
// ============================================================================
module sseq_an_end #(
    parameter int unsigned ACK_WAIT_CYC = sseq_pkg::ACK_WAIT_CYC,
    parameter int unsigned ACK_SEND_CYC = sseq_pkg::ACK_SEND_CYC
) (
    // Clock and reset.
    input wire logic ref_clk_i,
    input wire logic reset_i,
    // Link toward the exchange.
    sseq_link_if.an_mp link,
    // User side.
    input wire logic call_start_i,
    input wire logic send_req_i,
    input wire logic send_param_i,
    output logic rx_accept_o,
    output logic rx_accept_param_o,
    output logic release_o,
    output logic active_o
);
    import sseq_pkg::*;

    // Same engine as the far end; only the link direction differs.
    sseq_engine #(
        .ACK_WAIT_CYC(ACK_WAIT_CYC),
        .ACK_SEND_CYC(ACK_SEND_CYC)
    ) u_engine (
        .ref_clk_i(ref_clk_i),
        .reset_i(reset_i),
        .call_start_i(call_start_i),
        .send_req_i(send_req_i),
        .send_param_i(send_param_i),
        .rx_valid_i(link.l2a_valid),
        .rx_ack_i(link.l2a_ack),
        .rx_param_i(link.l2a_param),
        .rx_seq_i(link.l2a_seq),
        .tx_valid_o(link.a2l_valid),
        .tx_ack_o(link.a2l_ack),
        .tx_param_o(link.a2l_param),
        .tx_seq_o(link.a2l_seq),
        .rx_accept_o(rx_accept_o),
        .rx_accept_param_o(rx_accept_param_o),
        .release_o(release_o),
        .active_o(active_o)
    );

endmodule : sseq_an_end

`default_nettype wire

/* File: verilog/sseq_le_end.sv */
// Purpose: Exchange end of the signalling sequence checker link.
// Assumes: The engine module is compiled before this file.
// Notes:   Behaviour is identical to the access network end.

`timescale 1ns/1ns
`default_nettype none

module sseq_le_end #(
    parameter int unsigned ACK_WAIT_CYC = sseq_pkg::ACK_WAIT_CYC,
    parameter int unsigned ACK_SEND_CYC = sseq_pkg::ACK_SEND_CYC
) (
    // Clock and reset.
    input wire logic ref_clk_i,
    input wire logic reset_i,
    // Link toward the access network.
    sseq_link_if.le_mp link,
    // User side.
    input wire logic call_start_i,
    input wire logic send_req_i,
    input wire logic send_param_i,
    output logic rx_accept_o,
    output logic rx_accept_param_o,
    output logic release_o,
    output logic active_o
);
    import sseq_pkg::*;

    // The checker is symmetric, so the exchange runs the same engine.
    sseq_engine #(
        .ACK_WAIT_CYC(ACK_WAIT_CYC),
        .ACK_SEND_CYC(ACK_SEND_CYC)
    ) u_engine (
        .ref_clk_i(ref_clk_i),
        .reset_i(reset_i),
        .call_start_i(call_start_i),
        .send_req_i(send_req_i),
        .send_param_i(send_param_i),
        .rx_valid_i(link.a2l_valid),
        .rx_ack_i(link.a2l_ack),
        .rx_param_i(link.a2l_param),
        .rx_seq_i(link.a2l_seq),
        .tx_valid_o(link.l2a_valid),
        .tx_ack_o(link.l2a_ack),
        .tx_param_o(link.l2a_param),
        .tx_seq_o(link.l2a_seq),
        .rx_accept_o(rx_accept_o),
        .rx_accept_param_o(rx_accept_param_o),
        .release_o(release_o),
        .active_o(active_o)
    );

endmodule : sseq_le_end

`default_nettype wire

/* File: bench/sseq_link_chk.sv */
// Purpose: Watches the link between the two peer sequence checkers.
// Assumes: One call runs on this link and is never released.
// Notes:   An ack may report the count with or without the latest message.
`timescale 1ns/1ns
`default_nettype none
module sseq_link_chk #(
    parameter int SEND_CYC = 20
) (
    // Clock and reset.
    input wire logic ref_clk_i,
    input wire logic reset_i,
    // Both directions of the link.
    input wire logic a2l_valid,
    input wire logic a2l_ack,
    input wire sseq_pkg::sseq_seq_t a2l_seq,
    input wire logic l2a_valid,
    input wire logic l2a_ack,
    input wire sseq_pkg::sseq_seq_t l2a_seq
);
    import sseq_pkg::*;
    // ========================================================================
    // Helpers
    // ========================================================================
    // Slack covers the registered expiry and one deferral by a signal.
    localparam int DUE = SEND_CYC + 6;
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (reset_i);
    wire logic sig_a = a2l_valid && !a2l_ack;
    wire logic sig_l = l2a_valid && !l2a_ack;
    wire logic ack_a = a2l_valid && a2l_ack;
    wire logic ack_l = l2a_valid && l2a_ack;
    sseq_seq_t nxt_a_r;
    sseq_seq_t nxt_l_r;
    // Next send number due in each direction, seen on the wire.
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            nxt_a_r <= SEQ_RESET;
            nxt_l_r <= SEQ_RESET;
        end else begin
            if (sig_a) nxt_a_r <= a2l_seq + SEQ_ONE;
            if (sig_l) nxt_l_r <= l2a_seq + SEQ_ONE;
        end
    end
    // ========================================================================
    // Assertions
    // ========================================================================
    a_seq_step_a: assert property (sig_a |-> a2l_seq == nxt_a_r)
        else $error("access side send number out of step");
    l_seq_step_a: assert property (sig_l |-> l2a_seq == nxt_l_r)
        else $error("exchange side send number out of step");
    l_ack_value_a: assert property (ack_l |->
        l2a_seq == nxt_a_r || l2a_seq == nxt_a_r - SEQ_ONE)
        else $error("exchange ack reports wrong count");
    a_ack_value_a: assert property (ack_a |->
        a2l_seq == nxt_l_r || a2l_seq == nxt_l_r - SEQ_ONE)
        else $error("access ack reports wrong count");
    l_ack_due_a: assert property (sig_a |-> ##[1:DUE] ack_l)
        else $error("exchange never acknowledged a message");
    a_ack_due_a: assert property (sig_l |-> ##[1:DUE] ack_a)
        else $error("access side never acknowledged a message");
    l_ack_gap_a: assert property (ack_l |=> (!ack_l) [*8])
        else $error("exchange acks follow too closely");
    a_ack_gap_a: assert property (ack_a |=> (!ack_a) [*8])
        else $error("access side acks follow too closely");
endmodule : sseq_link_chk
`default_nettype wire

/* File: bench/tb_signal_seq_error_detect.sv */
// Purpose: Drives both peer ends, and a lone end against a fault driver.
// Assumes: Timer lengths shortened by parameter; 20 MHz clock.
// Notes:   The lone end meets errors that a correct peer never makes.
`timescale 1ns/1ns
`default_nettype none
module tb_signal_seq_error_detect;
    import sseq_pkg::*;
    // ========================================================================
    // Set-up
    // ========================================================================
    localparam int WT = 40;
    localparam int ST = 20;
    localparam int WT2 = 200;
    logic ref_clk_i;
    logic reset_i;
    // Inputs are {call, send, param}; outputs {accept, param, release, active}.
    logic [2:0] a_in, l_in, b_in;
    logic [3:0] a_o, l_o, b_o;
    logic rel;
    int n_fail = 0;
    int compares = 0;
    int cyc = 0;
    int n, nv;
    // Rows hold {from exchange, parameter, expected send number}.
    logic [8:0] rows [6] = '{9'h000, 9'h081, 9'h180, 9'h002, 9'h101, 9'h083};
    sseq_link_if lk();
    sseq_link_if lk2();
    sseq_an_end #(.ACK_WAIT_CYC(WT), .ACK_SEND_CYC(ST)) i_sseq_an_end (
        .ref_clk_i(ref_clk_i), .reset_i(reset_i), .link(lk.an_mp),
        .call_start_i(a_in[2]), .send_req_i(a_in[1]), .send_param_i(a_in[0]),
        .rx_accept_o(a_o[3]), .rx_accept_param_o(a_o[2]),
        .release_o(a_o[1]), .active_o(a_o[0]));
    sseq_le_end #(.ACK_WAIT_CYC(WT), .ACK_SEND_CYC(ST)) i_sseq_le_end (
        .ref_clk_i(ref_clk_i), .reset_i(reset_i), .link(lk.le_mp),
        .call_start_i(l_in[2]), .send_req_i(l_in[1]), .send_param_i(l_in[0]),
        .rx_accept_o(l_o[3]), .rx_accept_param_o(l_o[2]),
        .release_o(l_o[1]), .active_o(l_o[0]));
    // The long wait timer here lets a full window go out before it fires.
    sseq_an_end #(.ACK_WAIT_CYC(WT2), .ACK_SEND_CYC(ST)) i_sseq_an_end_2 (
        .ref_clk_i(ref_clk_i), .reset_i(reset_i), .link(lk2.an_mp),
        .call_start_i(b_in[2]), .send_req_i(b_in[1]), .send_param_i(b_in[0]),
        .rx_accept_o(b_o[3]), .rx_accept_param_o(b_o[2]),
        .release_o(b_o[1]), .active_o(b_o[0]));
    sseq_link_chk #(.SEND_CYC(ST)) i_sseq_link_chk (.ref_clk_i(ref_clk_i),
        .reset_i(reset_i), .a2l_valid(lk.a2l_valid), .a2l_ack(lk.a2l_ack),
        .a2l_seq(lk.a2l_seq), .l2a_valid(lk.l2a_valid),
        .l2a_ack(lk.l2a_ack), .l2a_seq(lk.l2a_seq));
    // Free-running 20 MHz clock.
    initial begin
        ref_clk_i = 1'b0;
        forever #25 ref_clk_i = ~ref_clk_i;
    end
    // A hang is cut short well past the expected run length.
    always @(posedge ref_clk_i) begin
        cyc = cyc + 1;
        if (cyc == 5000) begin
            n_fail = n_fail + 1;
            give_verdict();
        end
    end
    // ========================================================================
    // Tasks
    // ========================================================================
    // Inputs change 1 ns after the edge so no race with the design.
    task automatic tick();
        @(posedge ref_clk_i);
        #1;
    endtask : tick
    task automatic check(input logic [9:0] seen, input logic [9:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: seen %0h expected %0h", $time,
                seen, exp);
        end
    endtask : check
    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : give_verdict
    // Frame {valid, ack, param, seq} of a2l, l2a, or the lone end's a2l.
    function automatic logic [9:0] fr(input int w);
        case (w)
            0: fr = {lk.a2l_valid, lk.a2l_ack, lk.a2l_param, lk.a2l_seq};
            1: fr = {lk.l2a_valid, lk.l2a_ack, lk.l2a_param, lk.l2a_seq};
            default: fr = {lk2.a2l_valid, lk2.a2l_ack, lk2.a2l_param,
                lk2.a2l_seq};
        endcase
    endfunction : fr
    // One message from the fault driver; released lines show the inverse.
    task automatic drv(input logic ak, input sseq_seq_t sq);
        {lk2.l2a_valid, lk2.l2a_ack, lk2.l2a_seq} = {1'b1, ak, sq};
        tick();
        {lk2.l2a_valid, lk2.l2a_ack, lk2.l2a_seq} = {1'b0, ~ak, ~sq};
    endtask : drv
    task automatic bcall();
        b_in[2] = 1'b1;
        tick();
        b_in[2] = 1'b0;
    endtask : bcall
    task automatic bsend(input int k);
        b_in[1] = 1'b1;
        repeat (k) tick();
        b_in[1] = 1'b0;
    endtask : bsend
    task automatic wait_rel();
        n = 0;
        while (b_o[1] !== 1'b1 && n < 400) begin
            tick();
            n++;
        end
    endtask : wait_rel
    // The main pair idles; with all acked no release may appear.
    task automatic idle();
        rel = 1'b0;
        repeat (50) begin
            tick();
            rel |= a_o[1] | l_o[1];
        end
        check({7'h00, rel, a_o[0], l_o[0]}, 10'h003);
    endtask : idle
    // ========================================================================
    // Main sequence
    // ========================================================================
    initial begin
        {a_in, l_in, b_in} = 9'h000;
        {lk2.l2a_valid, lk2.l2a_ack, lk2.l2a_param, lk2.l2a_seq} = 10'h000;
        reset_i = 1'b1;
        repeat (20) @(posedge ref_clk_i);
        #1 reset_i = 1'b0;
        check({2'b00, a_o, l_o}, 10'h000);
        check(fr(0) | fr(1), 10'h000);
        a_in[2] = 1'b1;
        l_in[2] = 1'b1;
        tick();
        {a_in[2], l_in[2]} = 2'b00;
        check({8'h00, a_o[0], l_o[0]}, 10'h003);
        $display("test done: reset and call start");
        foreach (rows[i]) begin
            if (rows[i][8]) l_in[1:0] = {1'b1, rows[i][7]};
            else a_in[1:0] = {1'b1, rows[i][7]};
            tick();
            {a_in[1:0], l_in[1:0]} = 4'h0;
            check(fr(int'(rows[i][8])), {2'b10, rows[i][7:0]});
            tick();
            check({6'h00, rows[i][8] ? a_o : l_o},
                {6'h00, 1'b1, rows[i][7], 2'b01});
        end
        $display("test done: message rows");
        nv = 0;
        repeat (60) begin
            tick();
            if (lk.l2a_valid && lk.l2a_ack) begin
                check(fr(1) & 10'h37F, 10'h304);
                nv++;
            end
            if (lk.a2l_valid && lk.a2l_ack) begin
                check(fr(0) & 10'h37F, 10'h302);
                nv++;
            end
        end
        check(10'(nv), 10'h002);
        idle();
        $display("test done: acknowledgements");
        a_in[1] = 1'b1;
        rel = 1'b0;
        for (int i = 0; i < 130; i++) begin
            tick();
            if (i == 129) a_in[1] = 1'b0;
            rel |= a_o[1] | l_o[1];
            check(fr(0), {3'b100, 7'(i + 4)});
        end
        check({9'h000, rel}, 10'h000);
        n = 0;
        while (n < 80 && (fr(1) & 10'h37F) !== 10'h306) begin
            tick();
            n++;
        end
        check(fr(1) & 10'h37F, 10'h306);
        idle();
        $display("test done: burst with wrap");
        bcall();
        // The fault driver feeds the inputs directly, so the one-cycle
        // answer already stands when drv returns.
        drv(1'b0, 7'h00);
        check({6'h00, b_o}, 10'h009);
        drv(1'b0, 7'h05);
        check({6'h00, b_o}, 10'h002);
        nv = 0;
        repeat (40) begin
            tick();
            nv += lk2.a2l_valid;
        end
        check(10'(nv), 10'h000);
        $display("test done: gap in received numbers");
        bcall();
        bsend(1);
        check(fr(2), 10'h200);
        repeat (20) tick();
        bsend(1);
        wait_rel();
        check({9'h000, n >= WT2 - 22 && n <= WT2 - 20}, 10'h001);
        bcall();
        bsend(2);
        repeat (20) tick();
        drv(1'b1, 7'h01);
        wait_rel();
        check({9'h000, n >= WT2 - 1 && n <= WT2 + 1}, 10'h001);
        $display("test done: wait timer");
        bcall();
        bsend(2);
        drv(1'b1, 7'h02);
        nv = 0;
        repeat (WT2 + 10) begin
            tick();
            nv += b_o[1];
        end
        check(10'(nv), 10'h000);
        drv(1'b1, 7'h05);
        check({6'h00, b_o}, 10'h002);
        $display("test done: ack validity");
        bcall();
        {nv, rel} = 0;
        b_in[1] = 1'b1;
        for (int i = 0; i < 130; i++) begin
            tick();
            if (i == 127) b_in[1] = 1'b0;
            nv += lk2.a2l_valid;
            rel |= b_o[1];
        end
        check({rel, 9'(nv)}, 10'h27F);
        $display("test done: window overflow");
        give_verdict();
    end
endmodule : tb_signal_seq_error_detect
`default_nettype wire
